// File: logic/ctrl_port_pkg.sv
package ctrl_port_pkg;

   // Bus widths and field positions
   localparam int ADDR_W      = 15;
   localparam int DATA_W      = 16;
   localparam int CODE_W      = 4;
   localparam int EXT_MSB     = 14;
   localparam int EXT_LSB     = 12;
   localparam int SEL_MSB     = 11;
   localparam int CNT_W       = 2;

   // Cycle counts on the link clock
   localparam logic [CNT_W-1:0] MEM_LAST_CNT   = 2'h3;
   localparam logic [CNT_W-1:0] SER_STROBE_CNT = 2'h2;
   localparam logic [CNT_W-1:0] SER_SAMPLE_CNT = 2'h3;

   // Reset values
   localparam logic [CODE_W-1:0] MASK_RESET = 4'h0;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;

   typedef enum logic [2:0] {
      OP_MEM_READ,
      OP_MEM_WRITE,
      OP_LOAD_SERIAL,
      OP_SET_BIT_ZERO,
      OP_SET_BIT_ONE,
      OP_STORE_SERIAL,
      OP_TEST_BIT,
      OP_EXT_INSTR
   } op_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_MEM,
      ST_SER,
      ST_RSP,
      ST_RELEASED
   } link_fsm_type;

   // Command from the core: address holds A0 in bit 14
   typedef struct packed {
      op_type              op;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
   } cmd_type;

   // Open-collector pin group; same layout for values and enables
   typedef struct packed {
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   data;
      logic                write_strobe_n;
      logic                memory_cycle_n;
      logic                data_in_indicator;
      logic                bus_release_ack;
   } bus_pins_type;

   // Input pins seen by the link logic
   typedef struct packed {
      logic                serial_io_in;
      logic                irq_request_n;
      logic [CODE_W-1:0]   irq_code;
      logic                bus_release_req_n;
      logic [DATA_W-1:0]   data;
   } pin_in_type;

   typedef struct packed {
      logic                rst_m;
      logic                rst_s;
      pin_in_type          pin_m;
      pin_in_type          pin_s;
      link_fsm_type        state;
      logic [CNT_W-1:0]    cnt;
      cmd_type             cmd;
      logic [DATA_W-1:0]   rdata;
      logic [CODE_W-1:0]   code_hold;
      logic                irq_seen;
      logic [CODE_W-1:0]   mask;
      logic                irq_armed;
      logic                irq_send;
      bus_pins_type        bus;
      bus_pins_type        bus_oe;
      logic                strobe;
      logic                serial_out;
   } link_state_type;

   typedef struct packed {
      logic [CODE_W-1:0]   mask_sent;
      logic                rel_m;
      logic                rel_s;
   } ref_state_type;

endpackage : ctrl_port_pkg

// File: logic/xfer_sync.sv
`timescale 1ns/1ps
`default_nettype none
module xfer_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             src_clk_i,
   input  wire logic             src_rst_i,
   input  wire logic             src_valid_i,
   input  wire logic [WIDTH-1:0] src_data_i,
   output logic                  src_ready_o,
   input  wire logic             dst_clk_i,
   input  wire logic             dst_rst_i,
   input  wire logic             dst_ready_i,
   output logic                  dst_valid_o,
   output logic [WIDTH-1:0]      dst_data_o
);

   typedef struct packed {
      logic             req;
      logic             ack_m;
      logic             ack_s;
      logic [WIDTH-1:0] data;
   } src_state_type;

   typedef struct packed {
      logic             req_m;
      logic             req_s;
      logic             ack;
      logic             valid;
      logic [WIDTH-1:0] data;
   } dst_state_type;

   src_state_type src, next_src;
   dst_state_type dst, next_dst;

   // Source side: toggle a request, hold the word until the toggle returns
   always_comb begin
      next_src       = src;
      next_src.ack_m = dst.ack;
      next_src.ack_s = src.ack_m;
      if (src_valid_i && (src.req == src.ack_s)) begin
         next_src.req  = ~src.req;
         next_src.data = src_data_i;
      end
      if (src_rst_i) begin
         next_src = '0;
      end
   end

   always_ff @(posedge src_clk_i) begin
      src <= next_src;
   end

   assign src_ready_o = (src.req == src.ack_s);

   // Destination side: word is stable while the toggles differ
   always_comb begin
      next_dst       = dst;
      next_dst.req_m = src.req;
      next_dst.req_s = dst.req_m;
      if (dst.valid && dst_ready_i) begin
         next_dst.valid = 1'b0;
         next_dst.ack   = ~dst.ack;
      end else if (!dst.valid && (dst.req_s != dst.ack)) begin
         next_dst.valid = 1'b1;
         next_dst.data  = src.data;
      end
      if (dst_rst_i) begin
         next_dst = '0;
      end
   end

   always_ff @(posedge dst_clk_i) begin
      dst <= next_dst;
   end

   assign dst_valid_o = dst.valid;
   assign dst_data_o  = dst.data;

endmodule : xfer_sync
`default_nettype wire

// File: logic/ctrl_port.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_port (
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        link_clk_i,
   input  wire logic                        cmd_valid_i,
   input  wire ctrl_port_pkg::cmd_type      cmd_i,
   output logic                             cmd_ready_o,
   output logic                             rsp_valid_o,
   output logic [ctrl_port_pkg::DATA_W-1:0] rsp_data_o,
   input  wire logic [ctrl_port_pkg::CODE_W-1:0] irq_mask_i,
   output logic                             irq_start_o,
   output logic [ctrl_port_pkg::CODE_W-1:0] irq_code_o,
   output logic                             bus_released_o,
   output logic                             serial_io_strobe_o,
   output logic                             serial_io_out_o,
   input  wire logic                        serial_io_in_i,
   input  wire logic                        irq_request_n_i,
   input  wire logic [ctrl_port_pkg::CODE_W-1:0] irq_code_i,
   input  wire logic                        bus_release_req_n_i,
   input  wire logic [ctrl_port_pkg::DATA_W-1:0] data_i,
   output ctrl_port_pkg::bus_pins_type      bus_o,
   output ctrl_port_pkg::bus_pins_type      bus_oe_o
);
   import ctrl_port_pkg::*;

   // Pin side runs on the link clock; the core side
   // keeps only the mask copy and the release flops
   link_state_type     link, next_link;
   ref_state_type      rs, next_rs;
   pin_in_type         pin_in;
   logic               cmd_avail;
   cmd_type            cmd_link;
   logic               cmd_take;
   logic               rsp_send;
   logic               rsp_free;
   logic               mask_new;
   logic [CODE_W-1:0]  mask_link;
   logic               mask_send;
   logic               mask_free;
   logic               irq_free;
   logic               irq_hit;

   // Command words from the core into the link domain
   // Toggle handshake: the word is read only after
   // the toggle has crossed, never while it moves
   xfer_sync #(.WIDTH($bits(cmd_type))) cmd_xfer (
      .src_clk_i   (ref_clk_i),
      .src_rst_i   (rst_i),
      .src_valid_i (cmd_valid_i),
      .src_data_i  (cmd_i),
      .src_ready_o (cmd_ready_o),
      .dst_clk_i   (link_clk_i),
      .dst_rst_i   (link.rst_s),
      .dst_ready_i (cmd_take),
      .dst_valid_o (cmd_avail),
      .dst_data_o  (cmd_link)
   );

   // Completion and read data back to the core
   // Link side waits in ST_RSP until this is free
   xfer_sync #(.WIDTH(DATA_W)) rsp_xfer (
      .src_clk_i   (link_clk_i),
      .src_rst_i   (link.rst_s),
      .src_valid_i (rsp_send),
      .src_data_i  (link.rdata),
      .src_ready_o (rsp_free),
      .dst_clk_i   (ref_clk_i),
      .dst_rst_i   (rst_i),
      .dst_ready_i (1'b1),
      .dst_valid_o (rsp_valid_o),
      .dst_data_o  (rsp_data_o)
   );

   // Interrupt mask changes toward the link domain
   // Quick mask edits merge; the latest value wins
   xfer_sync #(.WIDTH(CODE_W)) mask_xfer (
      .src_clk_i   (ref_clk_i),
      .src_rst_i   (rst_i),
      .src_valid_i (mask_send),
      .src_data_i  (irq_mask_i),
      .src_ready_o (mask_free),
      .dst_clk_i   (link_clk_i),
      .dst_rst_i   (link.rst_s),
      .dst_ready_i (1'b1),
      .dst_valid_o (mask_new),
      .dst_data_o  (mask_link)
   );

   // Accepted interrupt code toward the core
   // One pulse per acceptance; the code is held
   xfer_sync #(.WIDTH(CODE_W)) irq_xfer (
      .src_clk_i   (link_clk_i),
      .src_rst_i   (link.rst_s),
      .src_valid_i (link.irq_send),
      .src_data_i  (link.code_hold),
      .src_ready_o (irq_free),
      .dst_clk_i   (ref_clk_i),
      .dst_rst_i   (rst_i),
      .dst_ready_i (1'b1),
      .dst_valid_o (irq_start_o),
      .dst_data_o  (irq_code_o)
   );

   // Core side: resend the mask whenever it differs from the copy sent
   // Release status is one level bit: two flops do
   always_comb begin
      next_rs       = rs;
      mask_send     = (irq_mask_i != rs.mask_sent);
      next_rs.rel_m = link.bus_oe.bus_release_ack == 1'b0;
      next_rs.rel_s = rs.rel_m;
      if (mask_send && mask_free) begin
         next_rs.mask_sent = irq_mask_i;
      end
      if (rst_i) begin
         next_rs = '{mask_sent: MASK_RESET, rel_m: 1'b0, rel_s: 1'b0};
      end
   end

   always_ff @(posedge ref_clk_i) begin
      rs <= next_rs;
   end

   assign bus_released_o = rs.rel_s;

   // Pin inputs gathered for the two-stage synchroniser
   // Nothing reads a pin before both flops
   assign pin_in = '{serial_io_in:      serial_io_in_i,
                     irq_request_n:     irq_request_n_i,
                     irq_code:          irq_code_i,       // Bit 3 is the msb line
                     bus_release_req_n: bus_release_req_n_i,
                     data:              data_i};

   // Code accepted when held code is within the mask; 0001 wins over 1111
   // Two low samples in a row, so a glitch starts nothing
   // Code 0000 compares like any other value
   assign irq_hit = !link.pin_s.irq_request_n && link.irq_seen && link.irq_armed
                    && !link.irq_send && (link.code_hold <= link.mask);

   // Link side: pins, interrupt compare, memory and serial sequencing
   always_comb begin
      next_link       = link;
      next_link.rst_m = rst_i;
      next_link.rst_s = link.rst_m;
      next_link.pin_m = pin_in;
      next_link.pin_s = link.pin_m;
      // Handshake strobes low unless a state raises them
      cmd_take        = 1'b0;
      rsp_send        = 1'b0;

      // Resample the code while the request is low
      next_link.irq_seen = !link.pin_s.irq_request_n;
      if (!link.pin_s.irq_request_n) begin
         next_link.code_hold = link.pin_s.irq_code;
      end else begin
         next_link.irq_armed = 1'b1;
      end

      // A new mask may accept a request refused so far
      if (mask_new) begin
         next_link.mask      = mask_link;
         next_link.irq_armed = 1'b1;
      end

      // Send flag waits for room in the crossing
      if (irq_hit) begin
         next_link.irq_send  = 1'b1;
         next_link.irq_armed = 1'b0;
      end else if (link.irq_send && irq_free) begin
         next_link.irq_send  = 1'b0;
      end

      // One operation at a time; release only between them
      case (link.state)
         ST_IDLE: begin
            next_link.bus.memory_cycle_n    = 1'b1;
            next_link.bus.write_strobe_n    = 1'b1;
            next_link.bus.data_in_indicator = 1'b0;
            next_link.bus_oe.data           = '0;
            if (!link.pin_s.bus_release_req_n) begin
               // Only entered between cycles, so the last one is complete
               next_link.state  = ST_RELEASED;
               next_link.bus_oe = '0;
            end else if (cmd_avail) begin
               cmd_take      = 1'b1;
               next_link.cmd = cmd_link;
               next_link.cnt = '0;
               next_link.bus.addr = cmd_link.addr;
               if (cmd_link.op == OP_MEM_READ || cmd_link.op == OP_MEM_WRITE) begin
                  next_link.state                 = ST_MEM;
                  next_link.bus.memory_cycle_n    = 1'b0;
                  next_link.bus.data_in_indicator = (cmd_link.op == OP_MEM_READ);
                  next_link.bus.data              = cmd_link.data;
                  next_link.bus_oe.data = (cmd_link.op == OP_MEM_WRITE) ? '1 : '0;
               end else begin
                  next_link.state = ST_SER;
                  case (cmd_link.op)
                     OP_SET_BIT_ZERO: next_link.serial_out = 1'b0;
                     OP_SET_BIT_ONE:  next_link.serial_out = 1'b1;
                     OP_LOAD_SERIAL:  next_link.serial_out = cmd_link.data[0];
                     default:         next_link.serial_out = link.serial_out;
                  endcase
               end
            end
         end

         ST_MEM: begin
            next_link.cnt = link.cnt + 1'b1;
            // Strobe low only while write data is on the bus
            if (link.cmd.op == OP_MEM_WRITE && link.cnt < MEM_LAST_CNT) begin
               next_link.bus.write_strobe_n = 1'b0;
            end
            // Read data has crossed both pin flops by now
            if (link.cnt == MEM_LAST_CNT) begin
               next_link.rdata                 = link.pin_s.data;
               next_link.bus.memory_cycle_n    = 1'b1;
               next_link.bus.write_strobe_n    = 1'b1;
               next_link.bus.data_in_indicator = 1'b0;
               next_link.bus_oe.data           = '0;
               next_link.state                 = ST_RSP;
            end
         end

         ST_SER: begin
            next_link.cnt    = link.cnt + 1'b1;
            next_link.strobe = 1'b0;
            if (link.cnt == SER_STROBE_CNT && link.cmd.op != OP_STORE_SERIAL
                && link.cmd.op != OP_TEST_BIT) begin
               // Data and address were set up three cycles before the rise
               next_link.strobe = 1'b1;
            end
            // Sample one cycle after the strobe slot
            if (link.cnt == SER_SAMPLE_CNT) begin
               next_link.rdata = DATA_RESET;
               if (link.cmd.op == OP_STORE_SERIAL || link.cmd.op == OP_TEST_BIT) begin
                  next_link.rdata[0] = link.pin_s.serial_io_in;
               end
               next_link.state = ST_RSP;
            end
         end

         // Wait until the response crossing is free
         ST_RSP: begin
            rsp_send = 1'b1;
            if (rsp_free) begin
               next_link.state = ST_IDLE;
            end
         end

         ST_RELEASED: begin
            next_link.bus_oe = '0;
            // Data stays undriven; only a write enables it
            if (link.pin_s.bus_release_req_n) begin
               // Queued commands wait in the crossing and run from here
               next_link.state                  = ST_IDLE;
               next_link.bus_oe.addr            = '1;
               next_link.bus_oe.write_strobe_n  = 1'b1;
               next_link.bus_oe.memory_cycle_n  = 1'b1;
               next_link.bus_oe.data_in_indicator = 1'b1;
               next_link.bus_oe.bus_release_ack = 1'b1;
            end
         end

         default: begin
            next_link.state = ST_IDLE;
         end
      endcase

      // Reset arrives two link edges late via its flops
      if (link.rst_s) begin
         next_link.state      = ST_IDLE;
         next_link.cnt        = '0;
         next_link.cmd        = '0;
         next_link.rdata      = DATA_RESET;
         next_link.code_hold  = '0;
         next_link.irq_seen   = 1'b0;
         next_link.mask       = MASK_RESET;
         next_link.irq_armed  = 1'b1;
         next_link.irq_send   = 1'b0;
         next_link.strobe     = 1'b0;
         next_link.serial_out = 1'b0;
         next_link.bus        = '{addr: ADDR_RESET, data: DATA_RESET, write_strobe_n: 1'b1,
                                  memory_cycle_n: 1'b1, data_in_indicator: 1'b0,
                                  bus_release_ack: 1'b0};
         next_link.bus_oe     = '{addr: '1, data: '0, write_strobe_n: 1'b1,
                                  memory_cycle_n: 1'b1, data_in_indicator: 1'b1,
                                  bus_release_ack: 1'b1};
      end
   end

   // One register stage for all link-side state
   always_ff @(posedge link_clk_i) begin
      link <= next_link;
   end

   // Pin outputs straight from link flops
   // No logic between flops and pins: no glitches
   assign serial_io_strobe_o = link.strobe;
   assign serial_io_out_o    = link.serial_out;
   assign bus_o              = link.bus;
   assign bus_oe_o           = link.bus_oe;

endmodule : ctrl_port
`default_nettype wire

// File: verif/ctrl_port_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_port_chk (
   input wire logic                             ref_clk_i,
   input wire logic                             rst_i,
   input wire logic                             link_clk_i,
   input wire logic [ctrl_port_pkg::CODE_W-1:0] irq_mask_i,
   input wire logic                             irq_start_o,
   input wire logic [ctrl_port_pkg::CODE_W-1:0] irq_code_o,
   input wire logic                             serial_io_strobe_o,
   input wire logic                             serial_io_out_o,
   input wire ctrl_port_pkg::bus_pins_type      bus_o,
   input wire ctrl_port_pkg::bus_pins_type      bus_oe_o
);
   import ctrl_port_pkg::*;

   // Serial strobe shape and what it qualifies
   a_strobe_one_cycle: assert property (@(posedge link_clk_i) disable iff (rst_i)
      $rose(serial_io_strobe_o) |=> !serial_io_strobe_o) else $error("strobe too long");
   a_out_held: assert property (@(posedge link_clk_i) disable iff (rst_i)
      serial_io_strobe_o |-> $stable(serial_io_out_o)) else $error("serial bit moved");
   a_strobe_bus_idle: assert property (@(posedge link_clk_i) disable iff (rst_i)
      serial_io_strobe_o |-> bus_oe_o.bus_release_ack && bus_o.memory_cycle_n
                             && (&bus_oe_o.addr)) else $error("strobe without address");
   // Release handshake and write data on the pins
   a_release_float: assert property (@(posedge link_clk_i) disable iff (rst_i)
      !bus_oe_o.bus_release_ack |-> bus_oe_o == '0) else $error("pin driven while released");
   a_release_after_cycle: assert property (@(posedge link_clk_i) disable iff (rst_i)
      $fell(bus_oe_o.bus_release_ack) |-> $past(bus_o.memory_cycle_n))
      else $error("release cut a memory cycle");
   a_write_has_data: assert property (@(posedge link_clk_i) disable iff (rst_i)
      bus_oe_o.write_strobe_n && !bus_o.write_strobe_n |-> (&bus_oe_o.data)
                                 && !bus_o.memory_cycle_n) else $error("write without data");
   // Interrupt acceptance in the core domain
   a_irq_in_mask: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      irq_start_o |-> irq_code_o <= irq_mask_i) else $error("code above mask accepted");
   a_irq_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      irq_start_o |=> !irq_start_o) else $error("start longer than one cycle");

   c_strobe: cover property (@(posedge link_clk_i) $rose(serial_io_strobe_o));
   c_release: cover property (@(posedge link_clk_i) $fell(bus_oe_o.bus_release_ack));
   c_write: cover property (@(posedge link_clk_i) !bus_o.write_strobe_n);
   c_irq: cover property (@(posedge ref_clk_i) irq_start_o);
endmodule : ctrl_port_chk

bind ctrl_port ctrl_port_chk u_chk (.ref_clk_i, .rst_i, .link_clk_i, .irq_mask_i,
   .irq_start_o, .irq_code_o, .serial_io_strobe_o, .serial_io_out_o, .bus_o, .bus_oe_o);
`default_nettype wire

// File: verif/far_side.sv
`timescale 1ns/1ps
`default_nettype none
module far_side (
   input wire logic                              link_clk_i,
   input wire ctrl_port_pkg::bus_pins_type       bus_o,
   input wire ctrl_port_pkg::bus_pins_type       bus_oe_o,
   input wire logic                              serial_io_strobe_o,
   input wire logic                              serial_io_out_o,
   input wire logic                              irq_on_i,
   input wire logic [ctrl_port_pkg::CODE_W-1:0]  irq_code_set_i,
   input wire logic                              hold_on_i,
   input wire logic [15:0]                       in_bits_i,
   output var ctrl_port_pkg::bus_pins_type       pin_o,
   output logic                                  serial_io_in_o,
   output logic                                  irq_request_n_o,
   output logic [ctrl_port_pkg::CODE_W-1:0]      irq_code_o,
   output logic                                  bus_release_req_n_o,
   output logic [ctrl_port_pkg::DATA_W-1:0]      data_o,
   output logic                                  cap_bit_o = 1'b0,
   output logic [2:0]                            cap_code_o = 3'h0,
   output logic [7:0]                            n_strobe_o = 8'h00
);
   import ctrl_port_pkg::*;
   logic [DATA_W-1:0] mem [16] = '{default: '1};
   logic              strobe_q = 1'b0;

   // Open-collector pins: undriven bits float high through pull-ups
   assign pin_o = bus_o | ~bus_oe_o;
   // Memory answers reads only; outside a read cycle this side leaves the data lines high
   assign data_o = pin_o.data & ((pin_o.data_in_indicator && !pin_o.memory_cycle_n)
                                 ? mem[pin_o.addr[3:0]] : '1);
   // Serial input bit chosen by the low address lines
   assign serial_io_in_o = in_bits_i[pin_o.addr[3:0]];
   // Source holds request and code, code bit 3 as most significant
   assign irq_request_n_o = !irq_on_i;
   assign irq_code_o = irq_code_set_i;
   assign bus_release_req_n_o = !hold_on_i;

   // Memory write and capture of the serial bit on the strobe rising edge
   always @(posedge link_clk_i) begin
      strobe_q <= serial_io_strobe_o;
      if (!pin_o.write_strobe_n && !pin_o.memory_cycle_n) begin
         mem[pin_o.addr[3:0]] <= pin_o.data;
      end
      if (serial_io_strobe_o && !strobe_q) begin
         cap_bit_o <= serial_io_out_o;
         cap_code_o <= pin_o.addr[14:12];
         n_strobe_o <= n_strobe_o + 8'h01;
      end
   end
endmodule : far_side
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ctrl_port_pkg::*;
   logic ref_clk_i = 0, link_clk_i = 0, rst_i = 1, cmd_valid_i = 0, irq_on = 0, hold_on = 0;
   logic cmd_ready_o, rsp_valid_o, irq_start_o, bus_released_o, strobe, sout, sin;
   logic irq_n, rel_n, cap_bit;
   cmd_type           cmd_i = '0;
   logic [CODE_W-1:0] irq_mask_i = '0, irq_code = '0, irq_code_o, irq_code_p;
   logic [DATA_W-1:0] rsp_data_o, data_i, r, in_bits = 16'h0060;
   logic [2:0]        cap_code;
   logic [7:0]        n_strobe;
   bus_pins_type      bus_o, bus_oe_o, pin;
   int                n_mismatch = 0, cmp_count = 0, cycles = 0;

   // Core clock and an unrelated link clock
   initial forever #2 ref_clk_i = ~ref_clk_i;
   initial begin
      #37;
      forever #80 link_clk_i = ~link_clk_i;
   end

   ctrl_port dut (.ref_clk_i, .rst_i, .link_clk_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
      .rsp_valid_o, .rsp_data_o, .irq_mask_i, .irq_start_o, .irq_code_o, .bus_released_o,
      .serial_io_strobe_o(strobe), .serial_io_out_o(sout), .serial_io_in_i(sin),
      .irq_request_n_i(irq_n), .irq_code_i(irq_code_p), .bus_release_req_n_i(rel_n),
      .data_i, .bus_o, .bus_oe_o);
   far_side far (.link_clk_i, .bus_o, .bus_oe_o, .serial_io_strobe_o(strobe),
      .serial_io_out_o(sout), .irq_on_i(irq_on), .irq_code_set_i(irq_code),
      .hold_on_i(hold_on), .in_bits_i(in_bits), .pin_o(pin), .serial_io_in_o(sin),
      .irq_request_n_o(irq_n), .irq_code_o(irq_code_p), .bus_release_req_n_o(rel_n),
      .data_o(data_i), .cap_bit_o(cap_bit), .cap_code_o(cap_code), .n_strobe_o(n_strobe));

   task automatic end_sim;
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   task automatic check(input bit ok, input string msg);
      cmp_count++;
      if (!ok) begin
         n_mismatch++;
         $display("mismatch %0t %s", $time, msg);
      end
   endtask : check

   // One command, held until taken, then wait for its response
   task automatic do_cmd(input op_type op, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      int n = 0;
      @(posedge ref_clk_i);
      cmd_valid_i <= 1'b1;
      cmd_i <= '{op, a, d};
      do @(negedge ref_clk_i); while (cmd_ready_o !== 1'b1);
      @(posedge ref_clk_i);
      cmd_valid_i <= 1'b0;
      do begin @(negedge ref_clk_i); n++; end while (rsp_valid_o !== 1'b1 && n < 3000);
      check(n < 3000, "no response");
      q = rsp_data_o;
   endtask : do_cmd

   task automatic t_mem;
      do_cmd(OP_MEM_WRITE, 15'h0003, 16'hA5C3, r);
      do_cmd(OP_MEM_WRITE, 15'h0004, 16'h5A3C, r);
      do_cmd(OP_MEM_READ, 15'h0003, 16'h0000, r);
      check(r === 16'hA5C3, "read back");
   endtask : t_mem

   task automatic t_serial_out;
      op_type     ops [5] = '{OP_LOAD_SERIAL, OP_SET_BIT_ZERO, OP_SET_BIT_ONE,
                              OP_LOAD_SERIAL, OP_EXT_INSTR};
      logic [4:0] bits = 5'b00101;
      logic [7:0] n0;
      for (int i = 0; i < 5; i++) begin
         n0 = n_strobe;
         do_cmd(ops[i], 15'h5000, {15'h0000, bits[i]}, r);
         check(n_strobe === n0 + 8'h01, "strobe count");
         if (i < 4) check(cap_bit === bits[i], "serial out bit");
         else check(cap_code === 3'b101, "external code");
      end
   endtask : t_serial_out

   task automatic t_serial_in;
      logic [7:0] n0;
      n0 = n_strobe;
      for (int i = 0; i < 4; i++) begin
         do_cmd(i[0] ? OP_TEST_BIT : OP_STORE_SERIAL, 15'(i + 4), 16'h0000, r);
         check(r === {15'h0000, in_bits[i + 4]}, "serial in bit");
      end
      check(n_strobe === n0, "strobe on input");
   endtask : t_serial_in

   task automatic irq_try(input logic [3:0] code, input logic [3:0] mask,
                          input bit exp, input bit drop);
      int n = 0;
      @(posedge ref_clk_i);
      irq_mask_i <= mask;
      irq_on <= 1'b1;
      irq_code <= code;
      do begin @(negedge ref_clk_i); n++; end while (irq_start_o !== 1'b1 && n < 800);
      check((n < 800) == exp, "irq start");
      if (exp) check(irq_code_o === code, "irq code");
      if (drop) begin
         @(posedge ref_clk_i);
         irq_on <= 1'b0;
         repeat (400) @(posedge ref_clk_i);
      end
   endtask : irq_try

   task automatic t_release;
      time t0;
      fork
         do_cmd(OP_MEM_WRITE, 15'h0006, 16'h3C5A, r);
         begin
            repeat (220) @(posedge ref_clk_i);
            hold_on <= 1'b1;
         end
      join
      for (int n = 0; n < 800 && bus_released_o !== 1'b1; n++) @(negedge ref_clk_i);
      check(bus_released_o === 1'b1, "not released");
      check(pin === '1, "pins driven while released");
      fork
         do_cmd(OP_MEM_READ, 15'h0006, 16'h0000, r);
         begin
            repeat (300) @(posedge ref_clk_i);
            t0 = $time;
            hold_on <= 1'b0;
         end
      join
      check($time > t0 && r === 16'h3C5A, "resume after release");
   endtask : t_release

   // Cut a hung run short
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_mismatch++;
         end_sim();
      end
   end

   // Main sequence
   initial begin
      repeat (10) @(posedge link_clk_i);
      @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge link_clk_i);
      t_mem();
      t_serial_out();
      t_serial_in();
      irq_try(4'h5, 4'h3, 1'b0, 1'b0);
      irq_try(4'h5, 4'h7, 1'b1, 1'b1);
      irq_try(4'h8, 4'h7, 1'b0, 1'b1);
      irq_try(4'h1, 4'h1, 1'b1, 1'b1);
      irq_try(4'hF, 4'hF, 1'b1, 1'b1);
      t_release();
      end_sim();
   end
endmodule : testbench
`default_nettype wire
